//--- logic/adc_readout_pkg.sv
// shared constants and types of the converter readout and control block
package adc_readout_pkg;

   // ==========================================================
   // register map (byte addresses)
   localparam int          AXI_ADDR_W   = 8;
   localparam logic [7:0]  OFS_MODE0    = 8'h00;
   localparam logic [7:0]  OFS_MODE1    = 8'h04;
   localparam logic [7:0]  OFS_RESULT0  = 8'h08;
   localparam logic [7:0]  OFS_RESULT3  = 8'h14;
   localparam logic [7:0]  OFS_IRQ_STAT = 8'h18;
   localparam logic [7:0]  OFS_IRQ_MASK = 8'h1C;

   // ==========================================================
   // fields
   localparam int M0_START_BIT  = 0;
   localparam int M0_SCAN_BIT   = 1;
   localparam int M0_REPEAT_BIT = 2;
   localparam int M0_ITM_BIT    = 3;
   localparam int M0_BUSY_BIT   = 6;
   localparam int M0_END_BIT    = 7;
   localparam int CHAN_W        = 3;
   localparam int M1_TRIG_BIT   = 4;
   localparam int UNREAD_BIT    = 0;
   localparam int RES_W         = 10;
   localparam int RES_SHIFT     = 6;
   localparam int NUM_PAIRS     = 4;
   localparam int PAIR_W        = 2;

   // ==========================================================
   // timing and counts
   localparam int         CONV_STATES    = 84;
   localparam logic [1:0] REP_IRQ_LAST   = 2'h3;
   localparam logic [1:0] AXI_OKAY       = 2'h0;
   localparam logic [1:0] AXI_SLVERR     = 2'h2;

   typedef enum logic [1:0]
   {
      MODE_FIXED_SINGLE = 2'b00,
      MODE_SCAN_SINGLE  = 2'b01,
      MODE_FIXED_REPEAT = 2'b10,
      MODE_SCAN_REPEAT  = 2'b11
   } conv_mode_type;

   typedef enum logic
   {
      CONV_IDLE = 1'b0,
      CONV_RUN  = 1'b1
   } conv_state_type;

   // analog front end steering
   typedef struct packed
   {
      logic              converting;
      logic [CHAN_W-1:0] channel;
   } analog_ctl_type;

endpackage : adc_readout_pkg

//--- logic/conv_timer.sv
// per-channel conversion time counter
`timescale 1ns/1ps
module conv_timer
   import adc_readout_pkg::*;
#(
   parameter int STATES = CONV_STATES
)
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // control
   input  wire logic start,
   output logic      done
);

   typedef struct packed
   {
      logic       active;
      logic [7:0] count;
      logic       done;
   } timer_type;

   timer_type r;
   timer_type n;

   always_comb
   begin
      n      = r;
      n.done = 1'b0;
      if (start)
      begin
         // restart wins over a finishing count
         n.active = 1'b1;
         n.count  = 8'(STATES - 2);
      end
      else if (r.active)
      begin
         if (r.count == 8'h00)
         begin
            n.active = 1'b0;
            n.done   = 1'b1;
         end
         else
         begin
            n.count = r.count - 8'h01;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r <= '0;
      else
         r <= n;
   end

   assign done = r.done;

endmodule : conv_timer

//--- logic/result_slot.sv
// one result register pair with its unread flag
`timescale 1ns/1ps
module result_slot
   import adc_readout_pkg::*;
(
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // store and read
   input  wire logic             store,
   input  wire logic [RES_W-1:0] value_in,
   input  wire logic             read_clr,
   output logic      [RES_W-1:0] value,
   output logic                  unread
);

   typedef struct packed
   {
      logic [RES_W-1:0] value;
      logic             unread;
   } slot_type;

   slot_type r;
   slot_type n;

   always_comb
   begin
      n = r;
      if (read_clr)
         n.unread = 1'b0;
      // a store in the read cycle keeps the flag set
      if (store)
      begin
         n.value  = value_in;
         n.unread = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r <= '0;
      else
         r <= n;
   end

   assign value  = r.value;
   assign unread = r.unread;

endmodule : result_slot

//--- logic/adc_result_readout_control.sv
// converter start/mode control and result readout behind an AXI4-Lite slave
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module adc_result_readout_control
   import adc_readout_pkg::*;
(
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite write
   input  wire logic [AXI_ADDR_W-1:0] awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   // axi4-lite read
   input  wire logic [AXI_ADDR_W-1:0] araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // analog side
   input  wire logic                  external_trigger_pin,
   input  wire logic [RES_W-1:0]      analog_result,
   output analog_ctl_type             analog_ctl,
   // interrupt
   output logic                       conversion_done_irq
);

   // ==========================================================
   // state
   typedef struct packed
   {
      conv_state_type            state;
      logic                      scan;
      logic                      repeat_m;
      logic                      itm;
      logic                      busy;
      logic                      end_flag;
      logic                      run_repeat;
      logic [CHAN_W-1:0]         code;
      logic                      trig_en;
      logic [CHAN_W-1:0]         cur;
      logic [PAIR_W-1:0]         slot;
      logic [1:0]                rep_cnt;
      logic                      trig_prev;
      logic                      stat;
      logic                      mask;
      logic                      aw_held;
      logic [AXI_ADDR_W-1:0]     waddr;
      logic                      w_held;
      logic [7:0]                wbyte;
      logic                      wlane;
      logic                      bvalid;
      logic [1:0]                bresp;
      logic                      rvalid;
      logic [1:0]                rresp;
      logic [31:0]               rdata;
   } ctl_type;

   localparam ctl_type CTL_RST = '{state: CONV_IDLE, trig_prev: 1'b1, default: '0};

   ctl_type                 r;
   ctl_type                 n;
   logic                    tstart;
   logic                    tdone;
   logic                    do_write;
   logic                    rd_take;
   logic                    fall;
   logic                    go;
   logic [NUM_PAIRS-1:0]    slot_store;
   logic [NUM_PAIRS-1:0]    slot_clr;
   logic [RES_W-1:0]        slot_val [NUM_PAIRS];
   logic [NUM_PAIRS-1:0]    slot_unread;
   logic [PAIR_W-1:0]       store_idx;
   conv_mode_type           mode;

   function automatic logic is_result(input logic [AXI_ADDR_W-1:0] a);
      return (a >= OFS_RESULT0) && (a <= OFS_RESULT3) && (a[1:0] == 2'b00);
   endfunction : is_result

   function automatic logic [PAIR_W-1:0] pair_of(input logic [AXI_ADDR_W-1:0] a);
      logic [AXI_ADDR_W-1:0] d;
      d = a - OFS_RESULT0;
      return d[PAIR_W+1:2];
   endfunction : pair_of

   // ==========================================================
   // next state
   always_comb
   begin
      n          = r;
      tstart     = 1'b0;
      go         = 1'b0;
      slot_clr   = '0;
      slot_store = '0;
      mode       = conv_mode_type'({r.repeat_m, r.scan});
      store_idx  = (r.run_repeat && !r.scan) ? r.slot : r.cur[PAIR_W-1:0];
      rd_take    = arvalid && !r.rvalid;
      do_write   = r.aw_held && r.w_held && !r.bvalid;
      fall       = r.trig_prev && !external_trigger_pin;
      n.trig_prev = external_trigger_pin;

      // read channel; result reads clear flags before new sets below
      if (r.rvalid && rready)
         n.rvalid = 1'b0;
      if (rd_take)
      begin
         n.rvalid = 1'b1;
         n.rresp  = AXI_OKAY;
         n.rdata  = '0;
         if (is_result(araddr))
         begin
            // left aligned value with unread flag in bit 0
            n.rdata[RES_SHIFT+RES_W-1:RES_SHIFT] = slot_val[pair_of(araddr)];
            n.rdata[UNREAD_BIT] = slot_unread[pair_of(araddr)];
            slot_clr[pair_of(araddr)] = 1'b1;
            n.end_flag = 1'b0;
         end
         else
         begin
            case (araddr)
               OFS_MODE0:
               begin
                  n.rdata[M0_SCAN_BIT]   = r.scan;
                  n.rdata[M0_REPEAT_BIT] = r.repeat_m;
                  n.rdata[M0_ITM_BIT]    = r.itm;
                  n.rdata[M0_BUSY_BIT]   = r.busy;
                  n.rdata[M0_END_BIT]    = r.end_flag;
               end
               OFS_MODE1:
               begin
                  n.rdata[CHAN_W-1:0]  = r.code;
                  n.rdata[M1_TRIG_BIT] = r.trig_en;
               end
               OFS_IRQ_STAT: n.rdata[0] = r.stat;
               OFS_IRQ_MASK: n.rdata[0] = r.mask;
               default:      n.rresp    = AXI_SLVERR;
            endcase
         end
      end

      // write channels, address and data taken in either order
      if (awvalid && !r.aw_held && !r.bvalid)
      begin
         n.aw_held = 1'b1;
         n.waddr   = awaddr;
      end
      if (wvalid && !r.w_held && !r.bvalid)
      begin
         n.w_held = 1'b1;
         n.wbyte  = wdata[7:0];
         n.wlane  = wstrb[0];
      end
      if (r.bvalid && bready)
         n.bvalid = 1'b0;
      if (do_write)
      begin
         n.aw_held = 1'b0;
         n.w_held  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = AXI_OKAY;
         if (is_result(r.waddr))
            n.bresp = AXI_OKAY;
         else
         begin
            case (r.waddr)
               OFS_MODE0:
                  if (r.wlane)
                  begin
                     n.scan     = r.wbyte[M0_SCAN_BIT];
                     n.repeat_m = r.wbyte[M0_REPEAT_BIT];
                     n.itm      = r.wbyte[M0_ITM_BIT];
                     go         = r.wbyte[M0_START_BIT];
                  end
               OFS_MODE1:
                  if (r.wlane)
                  begin
                     n.code    = r.wbyte[CHAN_W-1:0];
                     n.trig_en = r.wbyte[M1_TRIG_BIT];
                  end
               OFS_IRQ_STAT:
                  if (r.wlane && r.wbyte[0])
                     n.stat = 1'b0;
               OFS_IRQ_MASK:
                  if (r.wlane)
                     n.mask = r.wbyte[0];
               default: n.bresp = AXI_SLVERR;
            endcase
         end
      end

      // a trigger edge while converting is ignored
      if (fall && r.trig_en && (r.state == CONV_IDLE))
         go = 1'b1;

      // one channel finished
      if (tdone && (r.state == CONV_RUN))
      begin
         slot_store[store_idx] = 1'b1;
         n.end_flag = 1'b1;
         tstart     = 1'b1;
         if (r.run_repeat && !r.repeat_m)
         begin
            // repeat stopped by software: end after this channel
            n.state = CONV_IDLE;
            n.busy  = 1'b0;
            tstart  = 1'b0;
         end
         else
         begin
            case (mode)
               MODE_FIXED_SINGLE:
               begin
                  n.state = CONV_IDLE;
                  n.busy  = 1'b0;
                  n.stat  = 1'b1;
                  tstart  = 1'b0;
               end
               MODE_FIXED_REPEAT:
               begin
                  n.slot    = r.slot + 1'b1;
                  n.rep_cnt = r.rep_cnt + 1'b1;
                  if (!r.itm || (r.rep_cnt == REP_IRQ_LAST))
                     n.stat = 1'b1;
               end
               default:
               begin
                  if (r.cur == r.code)
                  begin
                     n.cur  = '0;
                     n.stat = 1'b1;
                     if (mode == MODE_SCAN_SINGLE)
                     begin
                        n.state = CONV_IDLE;
                        n.busy  = 1'b0;
                        tstart  = 1'b0;
                     end
                  end
                  else
                  begin
                     // mid-scan channel: keep the flag, but let a result read still clear it
                     n.end_flag = r.end_flag && !(rd_take && is_result(araddr));
                     n.cur      = r.cur + 1'b1;
                  end
               end
            endcase
         end
      end

      // start or restart wins over a finishing channel
      if (go)
      begin
         n.state      = CONV_RUN;
         n.busy       = 1'b1;
         n.run_repeat = n.repeat_m;
         n.cur        = n.scan ? '0 : n.code;
         n.slot       = '0;
         n.rep_cnt    = '0;
         tstart       = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r <= CTL_RST;
      else
         r <= n;
   end

   // ==========================================================
   // submodules
   conv_timer #(.STATES(CONV_STATES)) u_timer
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (tstart),
      .done    (tdone)
   );

   for (genvar g = 0; g < NUM_PAIRS; g++)
   begin : g_pair
      result_slot u_slot
      (
         .aclk     (aclk),
         .aresetn  (aresetn),
         .store    (slot_store[g]),
         .value_in (analog_result),
         .read_clr (slot_clr[g]),
         .value    (slot_val[g]),
         .unread   (slot_unread[g])
      );
   end

   // ==========================================================
   // outputs
   assign awready             = !r.aw_held && !r.bvalid;
   assign wready              = !r.w_held && !r.bvalid;
   assign bvalid              = r.bvalid;
   assign bresp               = r.bresp;
   assign arready             = !r.rvalid;
   assign rvalid              = r.rvalid;
   assign rresp               = r.rresp;
   assign rdata               = r.rdata;
   assign analog_ctl          = '{converting: (r.state == CONV_RUN), channel: r.cur};
   assign conversion_done_irq = r.stat && r.mask;

   // ==========================================================
   // checks
   logic [7:0] since_start;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         since_start <= '0;
      else if (tstart)
         since_start <= 8'h01;
      else if (since_start != 8'hFF)
         since_start <= since_start + 8'h01;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_unread_set;
      slot_store[0] |=> slot_unread[0];
   endproperty
   a_unread_set: assert property (p_unread_set) else $error("store left flag clear");

   property p_read_clear;
      rd_take && (araddr == OFS_RESULT0) && !slot_store[0] |=> !slot_unread[0];
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read kept flag");

   property p_end_clear;
      rd_take && is_result(araddr) && !tdone |=> !r.end_flag;
   endproperty
   a_end_clear: assert property (p_end_clear) else $error("end flag kept");

   property p_align;
      rd_take && (araddr == OFS_RESULT0) && !slot_store[0]
      |=> rvalid && (rdata[15:6] == slot_val[0]) && (rdata[5:1] == 5'h00);
   endproperty
   a_align: assert property (p_align) else $error("result misaligned");

   logic busy_cur_ok;
   assign busy_cur_ok = r.busy && (r.cur == r.code) && !r.run_repeat;
   property p_fixed_start;
      do_write && (r.waddr == OFS_MODE0) && r.wlane && (r.wbyte[2:0] == 3'h1)
      |=> busy_cur_ok;
   endproperty
   a_fixed_start: assert property (p_fixed_start) else $error("fixed start wrong");

   property p_scan_repeat;
      do_write && (r.waddr == OFS_MODE0) && r.wlane && (r.wbyte[2:0] == 3'h7)
      |=> r.busy && r.run_repeat && (r.cur == '0) ##1 !tdone;
   endproperty
   a_scan_repeat: assert property (p_scan_repeat) else $error("scan repeat start wrong");

   property p_trigger;
      fall && r.trig_en && (r.state == CONV_IDLE) |=> r.busy && (r.state == CONV_RUN);
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger did not start");

   property p_single_end;
      tdone && (r.state == CONV_RUN) && (mode == MODE_FIXED_SINGLE) && !go && !r.run_repeat
      |=> r.end_flag && !r.busy && r.stat;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single end wrong");

   property p_conv_time;
      tdone |-> (since_start == 8'(CONV_STATES));
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion time wrong");

endmodule : adc_result_readout_control

//--- tb/analog_source_model.sv
// analog front end model answering the converter's channel steering
`timescale 1ns/1ps
module analog_source_model
   import adc_readout_pkg::*;
(
   // clock
   input  wire logic             aclk,
   // steering and sample level
   input  wire analog_ctl_type   analog_ctl,
   input  wire logic [6:0]       level_base,
   output logic      [RES_W-1:0] analog_result
);
   // ==========================================================
   // sample source
   initial analog_result = 10'h2AA;

   // idle input toggles so a stale sample can never look valid
   always @(posedge aclk)
   begin
      if (analog_ctl.converting)
         analog_result <= {level_base, analog_ctl.channel};
      else
         analog_result <= ~analog_result;
   end
endmodule : analog_source_model

//--- tb/adc_result_readout_control_bench.sv
// self-checking bench of the converter readout and control block
`timescale 1ns/1ps
module adc_result_readout_control_bench;
   import adc_readout_pkg::*;
   // ==========================================================
   // signals
   logic                  aclk = 1'b0;
   logic                  aresetn = 1'b0;
   logic [AXI_ADDR_W-1:0] awaddr = 8'h00;
   logic                  awvalid = 1'b0;
   logic                  awready;
   logic [31:0]           wdata = 32'h0;
   logic [3:0]            wstrb = 4'hF;
   logic                  wvalid = 1'b0;
   logic                  wready;
   logic [1:0]            bresp;
   logic                  bvalid;
   logic                  bready = 1'b0;
   logic [AXI_ADDR_W-1:0] araddr = 8'h00;
   logic                  arvalid = 1'b0;
   logic                  arready;
   logic [31:0]           rdata;
   logic [1:0]            rresp;
   logic                  rvalid;
   logic                  rready = 1'b0;
   logic                  trig_n = 1'b1;
   logic [RES_W-1:0]      analog_result;
   analog_ctl_type        analog_ctl;
   logic                  conversion_done_irq;
   logic [6:0]            base = 7'h00;
   logic [65:0]           exp_q[$];
   logic [65:0]           pending;
   int                    bad_count = 0;
   int                    check_count = 0;
   int                    n;

   always #4 aclk = ~aclk;

   adc_result_readout_control DUT
   (
      .aclk                (aclk),
      .aresetn             (aresetn),
      .awaddr              (awaddr),
      .awvalid             (awvalid),
      .awready             (awready),
      .wdata               (wdata),
      .wstrb               (wstrb),
      .wvalid              (wvalid),
      .wready              (wready),
      .bresp               (bresp),
      .bvalid              (bvalid),
      .bready              (bready),
      .araddr              (araddr),
      .arvalid             (arvalid),
      .arready             (arready),
      .rdata               (rdata),
      .rresp               (rresp),
      .rvalid              (rvalid),
      .rready              (rready),
      .external_trigger_pin(trig_n),
      .analog_result       (analog_result),
      .analog_ctl          (analog_ctl),
      .conversion_done_irq (conversion_done_irq)
   );

   analog_source_model front
   (
      .aclk         (aclk),
      .analog_ctl   (analog_ctl),
      .level_base   (base),
      .analog_result(analog_result)
   );

   // ==========================================================
   // helpers
   task automatic end_of_test;
      // a read whose answer never came leaves its note behind
      if (exp_q.size() != 0)
         bad_count++;
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] res(input logic [2:0] ch, input logic u);
      return ({22'h0, base, ch} << RES_SHIFT) | {31'h0, u};
   endfunction : res

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int k;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      k = 0;
      do
      begin
         @(posedge aclk);
         k++;
         if (awvalid && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid && wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && k < 100);
      bready <= 1'b0;
      chk({bresp, 31'h0, bvalid}, {r, 31'h0, 1'b1});
   endtask : wr

   // expectation goes on the queue, the monitor compares the answer
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] r,
                     input logic [31:0] d);
      int k;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      exp_q.push_back({m, r, d & m});
      k = 0;
      do
      begin
         @(posedge aclk);
         k++;
      end
      while (arready !== 1'b1 && k < 100);
      arvalid <= 1'b0;
      do
      begin
         @(posedge aclk);
         k++;
      end
      while (rvalid !== 1'b1 && k < 200);
      rready <= 1'b0;
   endtask : rd

   task automatic wait_irq(output int c);
      c = 0;
      while (conversion_done_irq !== 1'b1 && c < 1000)
      begin
         @(posedge aclk);
         c++;
      end
   endtask : wait_irq

   task automatic wait_idle;
      int c;
      c = 0;
      while (analog_ctl.converting !== 1'b0 && c < 400)
      begin
         @(posedge aclk);
         c++;
      end
   endtask : wait_idle

   // ==========================================================
   // read monitor
   always @(posedge aclk)
   begin
      if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0)
      begin
         pending = exp_q.pop_front();
         chk({rresp, rdata & pending[65:34]}, pending[33:0]);
      end
   end

   // run is about 1500 cycles, so this only catches a hang
   initial
   begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      end_of_test();
   end

   // ==========================================================
   // scenarios
   initial
   begin
      base = 7'($urandom(32'hA394));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_MODE0, 32'hFFFFFFFF, AXI_OKAY, 32'h0);
      rd(OFS_RESULT0, 32'hFFFFFFFF, AXI_OKAY, 32'h0);
      rd(8'h20, 32'hFFFFFFFF, AXI_SLVERR, 32'h0);
      wr(8'h24, 32'h1, AXI_SLVERR);
      wr(OFS_IRQ_MASK, 32'h1, AXI_OKAY);
      wr(OFS_MODE1, 32'h03, AXI_OKAY);
      wr(OFS_MODE0, 32'h01, AXI_OKAY);
      wait_irq(n);
      chk({33'h0, n >= 78 && n <= 88}, 34'h1);
      rd(OFS_MODE0, 32'hFF, AXI_OKAY, 32'h80);
      wr(OFS_RESULT3, 32'hFFFFFFFF, AXI_OKAY);
      rd(OFS_RESULT3, 32'hFFFF, AXI_OKAY, res(3'h3, 1'b1));
      rd(OFS_RESULT3, 32'hFFFF, AXI_OKAY, res(3'h3, 1'b0));
      rd(OFS_MODE0, 32'hFF, AXI_OKAY, 32'h0);
      rd(OFS_IRQ_STAT, 32'h1, AXI_OKAY, 32'h1);
      wr(OFS_IRQ_STAT, 32'h1, AXI_OKAY);
      chk({33'h0, conversion_done_irq}, 34'h0);
      // trigger pin start on channel four
      base <= 7'($urandom());
      wr(OFS_MODE1, 32'h14, AXI_OKAY);
      trig_n <= 1'b0;
      @(posedge aclk);
      trig_n <= 1'b1;
      rd(OFS_MODE0, 32'h40, AXI_OKAY, 32'h40);
      wait_irq(n);
      rd(OFS_RESULT0, 32'hFFFF, AXI_OKAY, res(3'h4, 1'b1));
      wr(OFS_IRQ_STAT, 32'h1, AXI_OKAY);
      // scan single over channels 0..2
      wr(OFS_MODE1, 32'h02, AXI_OKAY);
      wr(OFS_MODE0, 32'h03, AXI_OKAY);
      wait_irq(n);
      chk({33'h0, n >= 240 && n <= 270}, 34'h1);
      for (int i = 0; i < 3; i++)
         rd(8'(OFS_RESULT0 + 4 * i), 32'hFFFF, AXI_OKAY, res(3'(i), 1'b1));
      rd(OFS_RESULT3, 32'h1, AXI_OKAY, 32'h0);
      // masking keeps the line low while status stays set
      wr(OFS_IRQ_MASK, 32'h0, AXI_OKAY);
      chk({33'h0, conversion_done_irq}, 34'h0);
      wr(OFS_IRQ_MASK, 32'h1, AXI_OKAY);
      chk({33'h0, conversion_done_irq}, 34'h1);
      wr(OFS_IRQ_STAT, 32'h1, AXI_OKAY);
      // scan repeat over channels 0..1, then stop
      wr(OFS_MODE1, 32'h01, AXI_OKAY);
      wr(OFS_MODE0, 32'h07, AXI_OKAY);
      wait_irq(n);
      rd(OFS_MODE0, 32'h46, AXI_OKAY, 32'h46);
      wr(OFS_IRQ_STAT, 32'h1, AXI_OKAY);
      wait_irq(n);
      chk({33'h0, n >= 150 && n <= 180}, 34'h1);
      wr(OFS_MODE0, 32'h02, AXI_OKAY);
      wait_idle();
      rd(OFS_MODE0, 32'h40, AXI_OKAY, 32'h0);
      wr(OFS_IRQ_STAT, 32'h1, AXI_OKAY);
      // fixed repeat on channel five, read while it runs
      wr(OFS_MODE1, 32'h05, AXI_OKAY);
      wr(OFS_MODE0, 32'h05, AXI_OKAY);
      wait_irq(n);
      rd(OFS_MODE0, 32'h46, AXI_OKAY, 32'h44);
      rd(OFS_RESULT0, 32'hFFC0, AXI_OKAY, res(3'h5, 1'b0));
      // restart with status on every fourth conversion only
      wr(OFS_MODE0, 32'h0D, AXI_OKAY);
      wr(OFS_IRQ_STAT, 32'h1, AXI_OKAY);
      wait_irq(n);
      chk({33'h0, n >= 320 && n <= 345}, 34'h1);
      rd(OFS_RESULT3, 32'hFFFF, AXI_OKAY, res(3'h5, 1'b1));
      wr(OFS_MODE0, 32'h00, AXI_OKAY);
      wait_idle();
      rd(OFS_MODE0, 32'h40, AXI_OKAY, 32'h0);
      repeat (3) @(posedge aclk);
      end_of_test();
   end
endmodule : adc_result_readout_control_bench
